//--- reader_irq_ctrl.sv
// Purpose: Interrupt status and mask registers of an HF reader, with AXI4-Lite access
// Assumes: Event inputs are one-cycle pulses from logic on MCLK; SET_DEFAULT likewise
// Notes:   Status registers clear on read, main summary bits on detail read; an event in the clearing cycle is kept
`timescale 1ns/1ps
`include "reader_irq_params.svh"

// Function
// - Mask register 15h masks timer, field, avoidance and bit-rate interrupts; one masks.
// - Mask register 16h masks error and wake-up interrupts; one masks.
// - Both mask registers load zero at power-up and on set-default.
// - Main status 17h bit 7 sets when the crystal oscillator is stable.
// - Main bit 6 sets on FIFO water level, receive or transmit.
// - Main bits 5,4,3,2: receive start, receive end, transmit end, collision.
// - Main bit 1 summarises timer/field events, bit 0 error/wake-up events.
// - Reading main status clears bits 7 to 2, not the summary bits.
// - Each summary bit clears only when its detail register is read.
// - Main and timer/field status reset to zero at power-up and set-default.
// - Status 18h bits 7 to 3: command done, timers, field rise and fall.
// - Status 18h bit 2 sets on external field during collision avoidance.
// - Status 18h bit 1 sets after guard time once own field is on.
// - Status 18h bit 0 sets when target recognises initiator bit rate.
// - Reading status 18h clears it to zero.
// - Status 19h holds CRC, parity, framing and wake-up flags, clears on read.
module reader_irq_ctrl
   import reader_irq_pkg::*;
(
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire axi_addr_t AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output axi_resp_t BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire axi_addr_t ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output axi_resp_t RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic SET_DEFAULT,
   input wire logic OSC_STABLE,
   input wire logic FIFO_LEVEL,
   input wire logic RX_START,
   input wire logic RX_END,
   input wire logic TX_END,
   input wire logic BIT_COLLISION,
   input wire byte_reg_t TIMER_FIELD_EVENT,
   input wire byte_reg_t ERROR_WAKEUP_EVENT,
   output logic IRQ
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   byte_reg_t timer_field_irq_mask;
   byte_reg_t error_wakeup_irq_mask;
   byte_reg_t main_irq_status;
   byte_reg_t timer_field_irq_status;
   byte_reg_t error_wakeup_irq_status;

   // ----------------------------------------
   // Bus front end
   // ----------------------------------------
   logic wr_req;
   axi_addr_t wr_addr;
   byte_reg_t wr_data;
   logic wr_lane0;
   logic wr_ok;
   logic rd_req;
   axi_addr_t rd_addr;
   byte_reg_t rd_data;
   logic rd_ok;

   reader_irq_axil u_axil (
      .clk(MCLK),
      .arst_n(ARST_N),
      .awaddr(AWADDR),
      .awvalid(AWVALID),
      .awready(AWREADY),
      .wdata(WDATA),
      .wstrb(WSTRB),
      .wvalid(WVALID),
      .wready(WREADY),
      .bresp(BRESP),
      .bvalid(BVALID),
      .bready(BREADY),
      .araddr(ARADDR),
      .arvalid(ARVALID),
      .arready(ARREADY),
      .rdata(RDATA),
      .rresp(RRESP),
      .rvalid(RVALID),
      .rready(RREADY),
      .wr_req(wr_req),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_lane0(wr_lane0),
      .wr_ok(wr_ok),
      .rd_req(rd_req),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic hits(input axi_addr_t addr, input logic [5:0] idx);
      hits = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
   endfunction

   wire wr_tmask = hits(wr_addr, `IDX_TIMER_FIELD_MASK);
   wire wr_emask = hits(wr_addr, `IDX_ERROR_WAKEUP_MASK);
   wire rd_tmask = hits(rd_addr, `IDX_TIMER_FIELD_MASK);
   wire rd_emask = hits(rd_addr, `IDX_ERROR_WAKEUP_MASK);
   wire rd_main = hits(rd_addr, `IDX_MAIN_STATUS);
   wire rd_tstat = hits(rd_addr, `IDX_TIMER_FIELD_STATUS);
   wire rd_estat = hits(rd_addr, `IDX_ERROR_WAKEUP_STATUS);

   // Status registers take no writes
   assign wr_ok = wr_tmask | wr_emask;
   assign rd_ok = rd_tmask | rd_emask | rd_main | rd_tstat | rd_estat;

   assign rd_data = rd_tmask ? timer_field_irq_mask :
                    rd_emask ? error_wakeup_irq_mask :
                    rd_main ? main_irq_status :
                    rd_tstat ? timer_field_irq_status :
                    rd_estat ? error_wakeup_irq_status : `REG_RESET;

   // ----------------------------------------
   // Read side effects
   // ----------------------------------------
   wire clr_main = rd_req & rd_main;
   wire clr_tstat = rd_req & rd_tstat;
   wire clr_estat = rd_req & rd_estat;

   // ----------------------------------------
   // Next values, set wins over clear
   // ----------------------------------------
   wire [7:2] main_events = {OSC_STABLE, FIFO_LEVEL, RX_START, RX_END, TX_END, BIT_COLLISION};
   wire [7:2] next_main_hi = (main_irq_status[7:2] & ~{6{clr_main}}) | main_events;
   wire next_tsum = (main_irq_status[`BIT_TIMER_FIELD_SUM] & ~clr_tstat) | (|TIMER_FIELD_EVENT);
   wire next_esum = (main_irq_status[`BIT_ERROR_WAKEUP_SUM] & ~clr_estat) | (|ERROR_WAKEUP_EVENT);
   wire byte_reg_t next_main = {next_main_hi, next_tsum, next_esum};
   // Bit order 7..0: command done, no-response, timer, field on, field off, avoidance hit, guard time, bit rate
   wire byte_reg_t next_tstat = (timer_field_irq_status & ~{8{clr_tstat}}) | TIMER_FIELD_EVENT;
   wire byte_reg_t next_estat = (error_wakeup_irq_status & ~{8{clr_estat}}) | ERROR_WAKEUP_EVENT;

   wire byte_reg_t next_tmask = (wr_req & wr_tmask & wr_lane0) ? wr_data : timer_field_irq_mask;
   wire byte_reg_t next_emask = (wr_req & wr_emask & wr_lane0) ? wr_data : error_wakeup_irq_mask;

   wire unmasked = (|next_main[7:2]) | (|(next_tstat & ~next_tmask)) | (|(next_estat & ~next_emask));

   // ----------------------------------------
   // Mask registers
   // ----------------------------------------
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         timer_field_irq_mask <= `REG_RESET;
         error_wakeup_irq_mask <= `REG_RESET;
      end else if (SET_DEFAULT) begin
         timer_field_irq_mask <= `REG_RESET;
         error_wakeup_irq_mask <= `REG_RESET;
      end else begin
         timer_field_irq_mask <= next_tmask;
         error_wakeup_irq_mask <= next_emask;
      end
   end

   // ----------------------------------------
   // Status registers
   // ----------------------------------------
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         main_irq_status <= `REG_RESET;
         timer_field_irq_status <= `REG_RESET;
         error_wakeup_irq_status <= `REG_RESET;
      end else if (SET_DEFAULT) begin
         main_irq_status <= `REG_RESET;
         timer_field_irq_status <= `REG_RESET;
         error_wakeup_irq_status <= `REG_RESET;
      end else begin
         main_irq_status <= next_main;
         timer_field_irq_status <= next_tstat;
         error_wakeup_irq_status <= next_estat;
      end
   end

   // ----------------------------------------
   // Interrupt request
   // ----------------------------------------
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= unmasked & ~SET_DEFAULT;
      end
   end
endmodule

//--- reader_irq_params.svh
// Purpose: Register offsets, field positions and reset values of the reader interrupt block
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   Definitions only
`ifndef READER_IRQ_PARAMS_SVH
`define READER_IRQ_PARAMS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_TIMER_FIELD_MASK 6'h15
`define IDX_ERROR_WAKEUP_MASK 6'h16
`define IDX_MAIN_STATUS 6'h17
`define IDX_TIMER_FIELD_STATUS 6'h18
`define IDX_ERROR_WAKEUP_STATUS 6'h19

// ----------------------------------------
// Main status bit positions
// ----------------------------------------
`define BIT_OSC_STABLE 7
`define BIT_FIFO_LEVEL 6
`define BIT_RX_START 5
`define BIT_RX_END 4
`define BIT_TX_END 3
`define BIT_COLLISION 2
`define BIT_TIMER_FIELD_SUM 1
`define BIT_ERROR_WAKEUP_SUM 0

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define REG_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

//--- reader_irq_pkg.sv
// Purpose: Types shared by the reader interrupt block
// Assumes: Nothing
// Notes:   Values live in reader_irq_params.svh
package reader_irq_pkg;
   typedef logic [7:0] byte_reg_t;
   typedef logic [1:0] axi_resp_t;
   typedef logic [7:0] axi_addr_t;
endpackage

//--- reader_irq_axil.sv
// Purpose: AXI4-Lite slave front end for the reader interrupt block
// Assumes: One write and one read under way at a time
// Notes:   Read strobe is the AR handshake cycle; write strobe fires once AW and W are both held
`timescale 1ns/1ps
`include "reader_irq_params.svh"

module reader_irq_axil
   import reader_irq_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire axi_addr_t awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output axi_resp_t bresp,
   output logic bvalid,
   input wire logic bready,
   input wire axi_addr_t araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output axi_resp_t rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_req,
   output axi_addr_t wr_addr,
   output byte_reg_t wr_data,
   output logic wr_lane0,
   input wire logic wr_ok,
   output logic rd_req,
   output axi_addr_t rd_addr,
   input wire byte_reg_t rd_data,
   input wire logic rd_ok
);
   logic aw_full;
   logic w_full;
   logic [31:0] wdata_hold;
   logic [3:0] wstrb_hold;
   wire aw_take = awvalid & awready;
   wire w_take = wvalid & wready;
   wire next_aw_full = (aw_full | aw_take) & ~wr_req;
   wire next_w_full = (w_full | w_take) & ~wr_req;
   wire next_bvalid = wr_req | (bvalid & ~bready);
   wire next_rvalid = rd_req | (rvalid & ~rready);

   // ----------------------------------------
   // Strobes toward the register file
   // ----------------------------------------
   assign wr_req = aw_full & w_full & ~bvalid;
   assign wr_data = wdata_hold[7:0];
   assign wr_lane0 = wstrb_hold[0];
   assign rd_req = arvalid & arready;
   assign rd_addr = araddr;

   // ----------------------------------------
   // Write channels
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         wr_addr <= 8'h00;
         wdata_hold <= 32'h0000_0000;
         wstrb_hold <= 4'h0;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         awready <= ~next_aw_full;
         wready <= ~next_w_full;
         bvalid <= next_bvalid;
         if (aw_take) begin
            wr_addr <= awaddr;
         end
         if (w_take) begin
            wdata_hold <= wdata;
            wstrb_hold <= wstrb;
         end
         if (wr_req) begin
            bresp <= wr_ok ? `RESP_OKAY : `RESP_DECERR;
         end
      end
   end

   // ----------------------------------------
   // Read channels
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
      end else begin
         arready <= ~next_rvalid;
         rvalid <= next_rvalid;
         if (rd_req) begin
            rdata <= {24'h00_0000, rd_data};
            rresp <= rd_ok ? `RESP_OKAY : `RESP_DECERR;
         end
      end
   end
endmodule

//--- reader_irq_ctrl_sva.sv
// Purpose: Port checks of the reader interrupt block
// Assumes: Byte address is four times the register index
// Notes:   Bound to reader_irq_ctrl
`timescale 1ns/1ps
module reader_irq_ctrl_sva
   import reader_irq_pkg::*;
(
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire axi_addr_t AWADDR,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire axi_resp_t BRESP,
   input wire logic BVALID,
   input wire axi_addr_t ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire axi_resp_t RRESP,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic SET_DEFAULT,
   input wire logic OSC_STABLE,
   input wire logic FIFO_LEVEL,
   input wire logic RX_START,
   input wire logic RX_END,
   input wire logic TX_END,
   input wire logic BIT_COLLISION,
   input wire logic IRQ
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   wire main_ev = OSC_STABLE | FIFO_LEVEL | RX_START | RX_END | TX_END | BIT_COLLISION;
   wire rd_take = ARVALID && ARREADY;
   wire wr_take = AWVALID && AWREADY && WVALID && WREADY;
   wire rd_map = ARADDR inside {8'h54, 8'h58, 8'h5C, 8'h60, 8'h64};
   chk_event_raises_irq:
      assert property (main_ev && !SET_DEFAULT |=> IRQ) else $error("irq missing after event");
   chk_default_drops_irq:
      assert property (SET_DEFAULT |=> !IRQ) else $error("irq after set default");
   chk_read_answer:
      assert property (rd_take |=> RVALID) else $error("no read answer");
   chk_read_hold:
      assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP)) else $error("read dropped");
   chk_unmapped_read:
      assert property (rd_take && !rd_map |=> RRESP == 2'h3 && RDATA == 32'h0000_0000) else $error("bad unmapped read");
   chk_rdata_upper:
      assert property (RVALID |-> RDATA[31:8] == 24'h00_0000) else $error("upper read bits set");
   chk_status_write:
      assert property (wr_take && AWADDR inside {8'h5C, 8'h60, 8'h64} |-> ##[1:2] (BVALID && BRESP == 2'h3))
      else $error("status write accepted");
   chk_mask_write_ok:
      assert property (wr_take && AWADDR inside {8'h54, 8'h58} |-> ##[1:2] (BVALID && BRESP == 2'h0))
      else $error("mask write refused");
   chk_ready_after_reset:
      assert property ($rose(ARST_N) |=> ARREADY && AWREADY) else $error("not ready after reset");
   cover property (rd_take && ARADDR == 8'h5C);
   cover property (SET_DEFAULT);
   cover property (BVALID && BRESP == 2'h3);
endmodule

bind reader_irq_ctrl reader_irq_ctrl_sva chk (.MCLK(MCLK), .ARST_N(ARST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .ARADDR(ARADDR),
   .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
   .SET_DEFAULT(SET_DEFAULT), .OSC_STABLE(OSC_STABLE), .FIFO_LEVEL(FIFO_LEVEL), .RX_START(RX_START),
   .RX_END(RX_END), .TX_END(TX_END), .BIT_COLLISION(BIT_COLLISION), .IRQ(IRQ));

//--- tb.sv
// Purpose: Self-checking bench for the reader interrupt block
// Assumes: Byte address is four times the register index
// Notes:   Events are one-cycle pulses
`timescale 1ns/1ps
module tb import reader_irq_pkg::*;;
   logic mclk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, set_default = 0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   axi_addr_t awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'h0;
   axi_resp_t bresp, rresp;
   logic [7:2] main_ev = 6'h00;
   byte_reg_t tf = 8'h00, ew = 8'h00;
   int fails = 0, total_checks = 0, cycles = 0;
   reader_irq_ctrl dut (.MCLK(mclk), .ARST_N(arst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .SET_DEFAULT(set_default), .OSC_STABLE(main_ev[7]),
      .FIFO_LEVEL(main_ev[6]), .RX_START(main_ev[5]), .RX_END(main_ev[4]), .TX_END(main_ev[3]),
      .BIT_COLLISION(main_ev[2]), .TIMER_FIELD_EVENT(tf), .ERROR_WAKEUP_EVENT(ew), .IRQ(irq));
   initial begin
      forever #5 mclk = ~mclk;
   end
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input axi_addr_t a, input byte_reg_t d, input logic [3:0] s = 4'h1, input axi_resp_t r = 2'h0);
      @(posedge mclk);
      awaddr <= a; awvalid <= 1'b1; wdata <= {24'h00_0000, d}; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check("bresp", 32'(bresp), 32'(r));
   endtask
   task automatic rd(input axi_addr_t a, input byte_reg_t d, input axi_resp_t r = 2'h0);
      @(posedge mclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      check("rdata", rdata, {24'h00_0000, d});
      check("rresp", 32'(rresp), 32'(r));
   endtask
   task automatic pulse(input byte_reg_t m, input byte_reg_t t, input byte_reg_t e, input logic sd);
      @(posedge mclk);
      main_ev <= m[7:2]; tf <= t; ew <= e; set_default <= sd;
      @(posedge mclk);
      main_ev <= 6'h00; tf <= 8'h00; ew <= 8'h00; set_default <= 1'b0;
      #1;
   endtask
   task automatic zeros();
      for (int j = 0; j < 5; j++) rd(8'h54 + 8'(4 * j), 8'h00);
      check("irq", irq, 1'b0);
   endtask
   // Detail event with a given mask; summary stays until the detail read
   task automatic detail(input int k, input int i, input byte_reg_t m, input logic ex);
      wr(k ? 8'h58 : 8'h54, m);
      pulse(8'h00, k ? 8'h00 : 8'(1 << i), k ? 8'(1 << i) : 8'h00, 1'b0);
      check("irq", irq, ex);
      rd(8'h5C, k ? 8'h01 : 8'h02);
      rd(8'h5C, k ? 8'h01 : 8'h02);
      rd(k ? 8'h64 : 8'h60, 8'(1 << i));
      rd(8'h5C, 8'h00);
      check("irq", irq, 1'b0);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      zeros();
      $display("test reset values done");
      wr(8'h54, 8'hA5);
      rd(8'h54, 8'hA5);
      wr(8'h58, 8'h5A);
      wr(8'h58, 8'h3C, 4'h0);
      rd(8'h58, 8'h5A);
      wr(8'h5C, 8'hFF, 4'h1, 2'h3);
      wr(8'h60, 8'hFF, 4'h1, 2'h3);
      wr(8'h70, 8'hFF, 4'h1, 2'h3);
      rd(8'h70, 8'h00, 2'h3);
      rd(8'h5C, 8'h00);
      $display("test register access done");
      for (int i = 2; i < 8; i++) begin
         pulse(8'(1 << i), 8'h00, 8'h00, 1'b0);
         check("irq", irq, 1'b1);
         rd(8'h5C, 8'(1 << i));
         rd(8'h5C, 8'h00);
         check("irq", irq, 1'b0);
      end
      $display("test main events done");
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 8; i++) begin
            detail(k, i, ~8'(1 << i), 1'b1);
            detail(k, i, 8'(1 << i), 1'b0);
         end
      end
      $display("test detail events done");
      wr(8'h54, 8'hFF);
      wr(8'h58, 8'hFF);
      pulse(8'h80, 8'hFF, 8'hFF, 1'b0);
      check("irq", irq, 1'b1);
      pulse(8'h00, 8'h00, 8'h00, 1'b1);
      zeros();
      $display("test set default done");
      end_of_test();
   end
endmodule
